// file: hw/hbc_core.sv
/*
 * Control and protection logic of a mono PWM power output stage: decodes
 * two complementary PWM pairs into half-bridge states, handles sleep and
 * mute-reset, latches short circuits and reports faults on an open-drain
 * three-bit code.
 * Assumes all inputs synchronous to clk; analog sensors arrive as levels.
 */
// Overview of operation
// (R01) B output follows pos/neg pair: 10 gives high, 01 gives low.
// (R02) A output decodes its own pair the same way.
// (R03) Equal pair inputs, low regulator or overheat force outputs low.
// (R04) Over-current shutdown leaves the outputs floating instead.
// (R05) Sleep low floats both outputs whatever else happens.
// (R06) Sleep low releases shutdown and both fault code pins.
// (R07) Mute-reset forces both outputs low and clears short latch.
// (R08) Sleep overrides mute-reset when both are asserted.
// (R09) During mute-reset all PWM inputs are ignored, outputs low.
// (R10) Short circuit latches float-state shutdown until mute-reset.
// (R11) Illegal input, overheat, low regulator recover when they clear.
// (R12) Stalled PWM activity counts as illegal input.
// (R13) Fault codes 000,001,010,011,110,111; 100 and 101 never appear.
// (R14) Warning temperature pulls code bit0 low, decoding continues.
// (R15) Overheat shutdown sets at high threshold, clears at warning level.
// (R16) Low regulator level raises its fault until the level returns.
// (R17) Status pins only drive low or release, never drive high.
// (R18) Partner keeps mute-reset low at power-up for 1 ms.
// (R19) Partner holds mute-reset 1 ms for reinitialization.
// (R20) Any fault shuts outputs down at once and pulls shutdown low.
// (R21) A counter flags stalled inputs after a configurable idle window.
`timescale 1ns/10ps

module hbc_core
(
   input  wire logic                          clk,
   input  wire logic                          rst_b,
   input  wire logic                          sleep_n,
   input  wire logic                          mute_b,
   input  wire logic                          drive_a_pos,
   input  wire logic                          drive_a_neg,
   input  wire logic                          drive_b_pos,
   input  wire logic                          drive_b_neg,
   input  wire logic                          over_current,
   input  wire logic                          temp_above_warn,
   input  wire logic                          temp_above_shut,
   input  wire logic                          regulator_out_a_ok,
   input  wire logic                          regulator_out_b_ok,
   input  wire logic [hbc_pkg::ACT_CNT_W-1:0] idle_limit,
   output logic                               bridge_out_a,
   output logic                               bridge_out_a_oe,
   output logic                               bridge_out_b,
   output logic                               bridge_out_b_oe,
   output logic                               shutdown_o,
   output logic                               shutdown_oe,
   output logic                               fault_code_bit1_o,
   output logic                               fault_code_bit1_oe,
   output logic                               fault_code_bit0_o,
   output logic                               fault_code_bit0_oe
);

   logic                 short_ff;
   logic                 hot_ff;
   logic                 stall_a;
   logic                 stall_b;
   logic                 pwm_live;
   logic                 illegal;
   logic                 reg_low;
   hbc_pkg::hbc_mode_t   mode;
   logic [2:0]           code;
   logic                 nxt_out_a;
   logic                 nxt_oe_a;
   logic                 nxt_out_b;
   logic                 nxt_oe_b;
   logic                 nxt_status_en;
   logic                 out_a_ff;
   logic                 oe_a_ff;
   logic                 out_b_ff;
   logic                 oe_b_ff;
   logic                 sd_oe_ff;
   logic                 b1_oe_ff;
   logic                 b0_oe_ff;

   // ----------------------------------------------------------------
   // activity monitors, one per pair
   // ----------------------------------------------------------------
   // reset ignores the inputs, so the idle count restarts there too
   assign pwm_live = sleep_n && mute_b;   // see (R09)

   hbc_activity_mon u_act_a
   (
      .clk        (clk),
      .rst_b      (rst_b),
      .enable     (pwm_live),
      .sig_pos    (drive_a_pos),
      .sig_neg    (drive_a_neg),
      .idle_limit (idle_limit),
      .stalled    (stall_a)
   );

   hbc_activity_mon u_act_b
   (
      .clk        (clk),
      .rst_b      (rst_b),
      .enable     (pwm_live),
      .sig_pos    (drive_b_pos),
      .sig_neg    (drive_b_neg),
      .idle_limit (idle_limit),
      .stalled    (stall_b)
   );

   // ----------------------------------------------------------------
   // fault conditions
   // ----------------------------------------------------------------
   // equal levels on either pair, or lost toggling, is illegal
   assign illegal = (drive_a_pos == drive_a_neg)     // see (R03)
                 || (drive_b_pos == drive_b_neg)
                 || stall_a || stall_b;              // see (R12)
   assign reg_low = !regulator_out_a_ok
                 || !regulator_out_b_ok;             // see (R16)

   // short latch: mute-reset clears and wins over a new event, since a
   // mute-reset must clear the short fault (not hot_ff); sleep blocks both set and clear
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         short_ff <= hbc_pkg::SHORT_LATCH_RST;
      else if (sleep_n && !mute_b)
         short_ff <= 1'b0;                           // see (R07)
      else if (sleep_n && over_current)
         short_ff <= 1'b1;                           // see (R10)
   end

   // overheat with hysteresis: set above shut level, clear below warning
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         hot_ff <= hbc_pkg::HOT_LATCH_RST;
      else if (temp_above_shut)
         hot_ff <= 1'b1;                             // see (R15)
      else if (!temp_above_warn)
         hot_ff <= 1'b0;                             // see (R15)
   end

   // ----------------------------------------------------------------
   // mode selection, strict priority
   // ----------------------------------------------------------------
   // the live over_current term makes the shutdown take effect in the
   // same cycle the latch is set, not one later
   always_comb
   begin
      if (!sleep_n)
         mode = hbc_pkg::MODE_SLEEP;                 // see (R08)
      else if (!mute_b)
         mode = hbc_pkg::MODE_MUTE;
      else if (short_ff || over_current)
         mode = hbc_pkg::MODE_SHORT;                 // see (R20)
      else if (illegal)
         mode = hbc_pkg::MODE_ILLEGAL;               // see (R11)
      else if (hot_ff || temp_above_shut)
         mode = hbc_pkg::MODE_HOT;
      else if (reg_low)
         mode = hbc_pkg::MODE_LOWREG;
      else
         mode = hbc_pkg::MODE_RUN;
   end

   // ----------------------------------------------------------------
   // output decode per mode
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_out_a     = 1'b0;
      nxt_out_b     = 1'b0;
      nxt_oe_a      = 1'b1;
      nxt_oe_b      = 1'b1;
      nxt_status_en = 1'b1;
      code          = hbc_pkg::CODE_NORMAL;
      unique case (mode)
         hbc_pkg::MODE_SLEEP:
         begin
            nxt_oe_a      = 1'b0;                    // see (R05)
            nxt_oe_b      = 1'b0;
            nxt_status_en = 1'b0;                    // see (R06)
         end
         hbc_pkg::MODE_MUTE:
         begin
            code = hbc_pkg::CODE_NORMAL;             // see (R09)
         end
         hbc_pkg::MODE_SHORT:
         begin
            nxt_oe_a = 1'b0;                         // see (R04)
            nxt_oe_b = 1'b0;
            code     = hbc_pkg::CODE_SHORT;
         end
         hbc_pkg::MODE_ILLEGAL:
         begin
            code = hbc_pkg::CODE_ILLEGAL;            // see (R03)
         end
         hbc_pkg::MODE_HOT:
         begin
            code = hbc_pkg::CODE_OVERTEMP;
         end
         hbc_pkg::MODE_LOWREG:
         begin
            code = hbc_pkg::CODE_LOWREG;             // see (R16)
         end
         hbc_pkg::MODE_RUN:
         begin
            nxt_out_a = drive_a_pos;                 // see (R02)
            nxt_out_b = drive_b_pos;                 // see (R01)
            code      = temp_above_warn ? hbc_pkg::CODE_WARN
                                        : hbc_pkg::CODE_NORMAL; // see (R14)
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registered bridge drive
   // ----------------------------------------------------------------
   // reset floats the bridge so nothing switches before the first edge
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         out_a_ff <= hbc_pkg::BRIDGE_OUT_RST;
         oe_a_ff  <= hbc_pkg::BRIDGE_OE_RST;
         out_b_ff <= hbc_pkg::BRIDGE_OUT_RST;
         oe_b_ff  <= hbc_pkg::BRIDGE_OE_RST;
      end
      else
      begin
         out_a_ff <= nxt_out_a;
         oe_a_ff  <= nxt_oe_a;
         out_b_ff <= nxt_out_b;
         oe_b_ff  <= nxt_oe_b;
      end
   end

   // ----------------------------------------------------------------
   // registered open-drain status pins
   // ----------------------------------------------------------------
   // a zero code bit means pull low; a one bit is only a release
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sd_oe_ff <= hbc_pkg::STATUS_OE_RST;
         b1_oe_ff <= hbc_pkg::STATUS_OE_RST;
         b0_oe_ff <= hbc_pkg::STATUS_OE_RST;
      end
      else
      begin
         // codes 100 and 101 have no mode, so they are never built
         sd_oe_ff <= nxt_status_en && !code[hbc_pkg::CODE_SD_POS]; // see (R13)
         b1_oe_ff <= nxt_status_en && !code[hbc_pkg::CODE_B1_POS];
         b0_oe_ff <= nxt_status_en && !code[hbc_pkg::CODE_B0_POS];
      end
   end

   assign bridge_out_a       = out_a_ff;
   assign bridge_out_a_oe    = oe_a_ff;
   assign bridge_out_b       = out_b_ff;
   assign bridge_out_b_oe    = oe_b_ff;
   // drive value fixed low so the pins wire-OR safely
   assign shutdown_o         = 1'b0;                 // see (R17)
   assign fault_code_bit1_o  = 1'b0;
   assign fault_code_bit0_o  = 1'b0;
   assign shutdown_oe        = sd_oe_ff;
   assign fault_code_bit1_oe = b1_oe_ff;
   assign fault_code_bit0_oe = b0_oe_ff;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_sleep_float:                                    // see (R05)
   assert property (@(posedge clk) disable iff (!rst_b)
      !sleep_n |=> !bridge_out_a_oe && !bridge_out_b_oe)
      else $error("bridge driven while asleep");

   a_sleep_release:                                  // see (R06)
   assert property (@(posedge clk) disable iff (!rst_b)
      !sleep_n |=> !shutdown_oe && !fault_code_bit1_oe
                   && !fault_code_bit0_oe)
      else $error("status pin pulled while asleep");

   a_mute_lowlow:                                    // see (R09)
   assert property (@(posedge clk) disable iff (!rst_b)
      sleep_n && !mute_b |=> bridge_out_a_oe && bridge_out_b_oe
                             && !bridge_out_a && !bridge_out_b
                             && !shutdown_oe)
      else $error("mute-reset did not give low-low");

   a_mute_clears:                                    // see (R07)
   assert property (@(posedge clk) disable iff (!rst_b)
      sleep_n && !mute_b |=> !short_ff)
      else $error("short latch survived mute-reset");

   a_short_float:                                    // see (R04)
   assert property (@(posedge clk) disable iff (!rst_b)
      sleep_n && mute_b && over_current
      |=> !bridge_out_a_oe && !bridge_out_b_oe && shutdown_oe
          && !fault_code_bit0_oe && fault_code_bit1_oe)
      else $error("over-current did not float outputs");

   // only a mute-reset sampled low may clear the latch; sleep keeps it
   a_short_holds:                                    // see (R10)
   assert property (@(posedge clk) disable iff (!rst_b)
      short_ff && mute_b |=> short_ff)
      else $error("short latch dropped without reset");

   a_illegal_low:                                    // see (R03)
   assert property (@(posedge clk) disable iff (!rst_b)
      sleep_n && mute_b && !short_ff && !over_current
      && (drive_b_pos == drive_b_neg)
      |=> bridge_out_a_oe && !bridge_out_a && bridge_out_b_oe
          && !bridge_out_b && shutdown_oe && fault_code_bit1_oe
          && fault_code_bit0_oe)
      else $error("equal inputs not reported as illegal");

   a_decode_b:                                       // see (R01)
   assert property (@(posedge clk) disable iff (!rst_b)
      mode == hbc_pkg::MODE_RUN
      |=> bridge_out_b_oe && (bridge_out_b == $past(drive_b_pos))
          && (bridge_out_a == $past(drive_a_pos)) && !shutdown_oe)
      else $error("normal decode wrong");

   a_hot_hyst:                                       // see (R15)
   assert property (@(posedge clk) disable iff (!rst_b)
      hot_ff && temp_above_warn |=> hot_ff)
      else $error("overheat cleared above warning level");

   a_warn_code:                                      // see (R14)
   assert property (@(posedge clk) disable iff (!rst_b)
      mode == hbc_pkg::MODE_RUN && temp_above_warn
      |=> fault_code_bit0_oe && !fault_code_bit1_oe && !shutdown_oe)
      else $error("warning code not shown");

   a_lowreg_code:                                    // see (R16)
   assert property (@(posedge clk) disable iff (!rst_b)
      mode == hbc_pkg::MODE_LOWREG
      |=> bridge_out_a_oe && !bridge_out_a && bridge_out_b_oe
          && !bridge_out_b && shutdown_oe && !fault_code_bit1_oe
          && !fault_code_bit0_oe)
      else $error("low regulator code or outputs wrong");

   a_no_reserved:                                    // see (R13)
   assert property (@(posedge clk) disable iff (!rst_b)
      !shutdown_oe |-> !fault_code_bit1_oe)
      else $error("reserved fault code produced");

endmodule

// file: hw/hbc_pkg.sv
/*
 * Shared constants and types for the H-bridge control and fault logic:
 * fault code encodings, code bit positions, reset values, counter width
 * and the operating mode enumeration.
 * Assumes a single 100 MHz clock and no register bus.
 */
package hbc_pkg;

   // ----------------------------------------------------------------
   // activity detector
   // ----------------------------------------------------------------
   localparam int ACT_CNT_W = 16;

   // ----------------------------------------------------------------
   // fault codes as {shutdown, code bit1, code bit0}
   // ----------------------------------------------------------------
   localparam logic [2:0] CODE_ILLEGAL  = 3'h0;
   localparam logic [2:0] CODE_SHORT    = 3'h1;
   localparam logic [2:0] CODE_OVERTEMP = 3'h2;
   localparam logic [2:0] CODE_LOWREG   = 3'h3;
   localparam logic [2:0] CODE_WARN     = 3'h6;
   localparam logic [2:0] CODE_NORMAL   = 3'h7;

   localparam int CODE_SD_POS = 2;
   localparam int CODE_B1_POS = 1;
   localparam int CODE_B0_POS = 0;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic SHORT_LATCH_RST = 1'b0;
   localparam logic HOT_LATCH_RST   = 1'b0;
   localparam logic BRIDGE_OUT_RST  = 1'b0;
   localparam logic BRIDGE_OE_RST   = 1'b0;
   localparam logic STATUS_OE_RST   = 1'b0;

   // ----------------------------------------------------------------
   // operating mode, highest priority first
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_SLEEP,
      MODE_MUTE,
      MODE_SHORT,
      MODE_ILLEGAL,
      MODE_HOT,
      MODE_LOWREG,
      MODE_RUN
   } hbc_mode_t;

endpackage

// file: hw/hbc_activity_mon.sv
/*
 * Watches one complementary PWM pair for toggling activity and flags a
 * stall when no transition is seen for idle_limit clock cycles.
 * Assumes inputs are synchronous to clk; idle_limit of zero disables it.
 */
`timescale 1ns/10ps

module hbc_activity_mon
(
   input  wire logic                          clk,
   input  wire logic                          rst_b,
   input  wire logic                          enable,
   input  wire logic                          sig_pos,
   input  wire logic                          sig_neg,
   input  wire logic [hbc_pkg::ACT_CNT_W-1:0] idle_limit,
   output logic                               stalled
);

   logic [1:0]                      prev_ff;
   logic [hbc_pkg::ACT_CNT_W-1:0]   cnt_ff;
   logic [hbc_pkg::ACT_CNT_W-1:0]   nxt_cnt;
   logic                            stall_ff;
   logic                            toggled;

   // ----------------------------------------------------------------
   // transition detection
   // ----------------------------------------------------------------
   assign toggled = ({sig_pos, sig_neg} != prev_ff);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         prev_ff <= 2'h0;
      else
         prev_ff <= {sig_pos, sig_neg};
   end

   // ----------------------------------------------------------------
   // idle counter, saturates at the limit
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_cnt = cnt_ff;
      if (!enable || toggled)
         nxt_cnt = '0;
      else if (cnt_ff < idle_limit)
         nxt_cnt = cnt_ff + 1'b1;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_ff <= '0;
      else
         cnt_ff <= nxt_cnt;
   end

   // registered flag; zero limit keeps detection off
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         stall_ff <= 1'b0;
      else
         stall_ff <= enable && (idle_limit != '0)
                     && (nxt_cnt >= idle_limit);   // see (R21)
   end

   assign stalled = stall_ff;

endmodule

// file: testbench/hbc_pwm_src.sv
/*
 * Model of the pwm modulator in front of the bridge control: two
 * complementary pairs toggling at different rates, with stall and
 * equal-level injection on command.
 * Assumes the bench clock; every output changes at its falling edge.
 */
`timescale 1ns/10ps

module hbc_pwm_src
(
   input  wire logic clk,
   input  wire logic run,
   input  wire logic eq_a,
   input  wire logic eq_b,
   output logic      a_pos,
   output logic      a_neg,
   output logic      b_pos,
   output logic      b_neg
);
   logic [2:0] cnt_ff = 3'h0;
   logic       pa_ff  = 1'b0;
   logic       pb_ff  = 1'b1;

   // a flips every 2 cycles, b every 3: well inside the idle window
   always @(negedge clk)
   begin
      if (run)
      begin
         cnt_ff <= (cnt_ff == 3'h5) ? 3'h0 : cnt_ff + 3'h1;
         if (cnt_ff[0])
            pa_ff <= !pa_ff;
         if (cnt_ff == 3'h2 || cnt_ff == 3'h5)
            pb_ff <= !pb_ff;
      end
   end

   // pairs stay complementary unless an equal level is commanded
   assign a_pos = pa_ff;
   assign a_neg = eq_a ? pa_ff : !pa_ff;
   assign b_pos = pb_ff;
   assign b_neg = eq_b ? pb_ff : !pb_ff;
endmodule

// file: testbench/hbc_core_tb_top.sv
/*
 * Self-checking bench for the bridge control: a reference model is
 * compared with every output at every falling edge while chk_en is set,
 * with out_a and out_b compared only while their enable is expected.
 * Assumes hbc_core and the pwm source model; inputs change at negedge.
 */
`timescale 1ns/10ps

module hbc_core_tb_top;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        sleep_n = 1'b1;
   logic        mute_b = 1'b0;
   logic        over_current = 1'b0;
   logic        warn = 1'b0;
   logic        shut = 1'b0;
   logic        ok_a = 1'b1;
   logic        ok_b = 1'b1;
   logic        run = 1'b1;
   logic        eq_a = 1'b0;
   logic        eq_b = 1'b0;
   logic [15:0] idle_limit = 16'h0008;
   logic        a_pos, a_neg, b_pos, b_neg;
   logic        out_a, oe_a, out_b, oe_b;
   logic        sd_o, sd_oe, b1_o, b1_oe, b0_o, b0_oe;
   logic        e_oe_a = 1'b0, e_oe_b = 1'b0, e_out_a = 1'b0;
   logic        e_out_b = 1'b0, m_short = 1'b0, m_hot = 1'b0, bad, hot;
   logic [2:0]  e_code = 3'h7;
   logic        chk_en = 1'b1;
   logic [31:0] r;
   int          seed = 86914;
   int          err_count = 0;
   int          compares = 0;
   int          cyc = 0;

   hbc_pwm_src u_src (.clk(clk), .run(run), .eq_a(eq_a), .eq_b(eq_b),
      .a_pos(a_pos), .a_neg(a_neg), .b_pos(b_pos), .b_neg(b_neg));

   hbc_core u_dut (.clk(clk), .rst_b(rst_b), .sleep_n(sleep_n),
      .mute_b(mute_b), .drive_a_pos(a_pos), .drive_a_neg(a_neg),
      .drive_b_pos(b_pos), .drive_b_neg(b_neg),
      .over_current(over_current), .temp_above_warn(warn),
      .temp_above_shut(shut), .regulator_out_a_ok(ok_a),
      .regulator_out_b_ok(ok_b), .idle_limit(idle_limit),
      .bridge_out_a(out_a), .bridge_out_a_oe(oe_a),
      .bridge_out_b(out_b), .bridge_out_b_oe(oe_b),
      .shutdown_o(sd_o), .shutdown_oe(sd_oe),
      .fault_code_bit1_o(b1_o), .fault_code_bit1_oe(b1_oe),
      .fault_code_bit0_o(b0_o), .fault_code_bit0_oe(b0_oe));

   // ----------------------------------------------------------------
   // clock and run limit
   // ----------------------------------------------------------------
   initial
   begin
      forever #5 clk = !clk;
   end

   // the whole run needs well under 1500 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [2:0] ex,
                      input logic [2:0] got);
      compares++;
      if (got !== ex)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // ----------------------------------------------------------------
   // reference model, one result per rising edge
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         {e_oe_a, e_oe_b, m_short, m_hot} = 4'h0;
         e_code = 3'h7;
      end
      else
      begin
         bad = (a_pos === a_neg) || (b_pos === b_neg);
         // hysteresis: shut level acts at once, latch runs in every mode
         hot = m_hot || shut;
         if (shut)
            m_hot = 1'b1;
         else if (!warn)
            m_hot = 1'b0;
         {e_oe_a, e_oe_b, e_out_a, e_out_b} = 4'hC;
         if (!sleep_n)
         begin
            {e_oe_a, e_oe_b} = 2'h0;
            e_code = 3'h7;
         end
         else if (!mute_b)
         begin
            m_short = 1'b0;
            e_code = 3'h7;
         end
         else
         begin
            m_short = m_short | over_current;
            if (m_short)
            begin
               {e_oe_a, e_oe_b} = 2'h0;
               e_code = 3'h1;
            end
            else if (bad)
               e_code = 3'h0;
            else if (hot)
               e_code = 3'h2;
            else if (!(ok_a && ok_b))
               e_code = 3'h3;
            else
            begin
               {e_out_a, e_out_b} = {a_pos, b_pos};
               e_code = warn ? 3'h6 : 3'h7;
            end
         end
      end
   end

   // outputs are settled at the falling edge, before new stimulus lands
   always @(negedge clk)
   begin
      if (chk_en)
      begin
         chk("oe_a", e_oe_a, oe_a);
         chk("oe_b", e_oe_b, oe_b);
         if (e_oe_a)
            chk("out_a", e_out_a, out_a);
         if (e_oe_b)
            chk("out_b", e_out_b, out_b);
         chk("code", e_code, ~{sd_oe, b1_oe, b0_oe});
         chk("od_low", 3'h0, {sd_o, b1_o, b0_o});
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      // mute held long after power-up; 1 ms shortened to 100 cycles
      repeat (50) @(negedge clk);
      eq_a = 1'b1;
      repeat (50) @(negedge clk);
      eq_a = 1'b0;
      mute_b = 1'b1;
      $display("test mute hold done");
      repeat (400)
      begin
         @(negedge clk);
         r = $random(seed);
         ok_a = r[3:0] != 4'h0;
         ok_b = r[7:4] != 4'h0;
         warn = r[11:8] > 4'h9;
         shut = r[11:8] > 4'hD;
         eq_a = r[15:12] == 4'h0;
         eq_b = r[19:16] == 4'h0;
      end
      {warn, shut, eq_a, eq_b, ok_a, ok_b} = 6'h03;
      repeat (5) @(negedge clk);
      $display("test random faults done");
      over_current = 1'b1;
      @(negedge clk);
      over_current = 1'b0;
      repeat (6) @(negedge clk);
      // sleep over mute: the latch must survive the mute pulse
      {sleep_n, mute_b, over_current} = 3'h1;
      repeat (4) @(negedge clk);
      {mute_b, over_current} = 2'h2;
      @(negedge clk);
      sleep_n = 1'b1;
      repeat (3) @(negedge clk);
      {mute_b, over_current} = 2'h1;
      repeat (3) @(negedge clk);
      {mute_b, over_current} = 2'h2;
      repeat (3) @(negedge clk);
      $display("test short latch done");
      chk_en = 1'b0;
      run = 1'b0;
      repeat (12) @(negedge clk);
      chk("stall_code", 3'h0, ~{sd_oe, b1_oe, b0_oe});
      chk("stall_oe", 3'h3, {oe_a, oe_b});
      chk("stall_out", 3'h0, {out_a, out_b});
      run = 1'b1;
      repeat (6) @(negedge clk);
      chk_en = 1'b1;
      repeat (10) @(negedge clk);
      $display("test stall done");
      finish_test();
   end
endmodule
